/* File: common/mcl_pkg.sv */
package mcl_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL  = 4'h0;
  localparam logic [3:0] OFS_MODE  = 4'h4;
  localparam logic [3:0] OFS_EVENT = 4'h8;
  localparam logic [3:0] OFS_STAT  = 4'hc;

  // Event register bit positions (write one to fire)
  localparam int unsigned EV_RING   = 0;
  localparam int unsigned EV_ANSWER = 1;
  localparam int unsigned EV_SMS    = 2;
  localparam int unsigned EV_URC    = 3;
  localparam int unsigned EV_DATA   = 4;
  localparam int unsigned EV_DIAL   = 5;
  localparam int unsigned EV_HANGUP = 6;
  localparam int unsigned EV_W      = 7;

  // Timing, in the units shown
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned RI_ON_MS     = 1000;
  localparam int unsigned RI_PERIOD_MS = 5000;
  localparam int unsigned WAKE_MS      = 5;
  localparam int unsigned RX_GRACE     = 3;

  // Power saving settings
  localparam logic [1:0] PSV_OFF  = 2'h0;
  localparam logic [1:0] PSV_RTS  = 2'h2;
  localparam logic [1:0] PSV_DTR  = 2'h3;

  typedef enum logic [1:0] {
    MCL_CMD,
    MCL_DATA,
    MCL_ONLINE
  } mcl_if_mode_t;

  typedef struct packed {
    logic [21:0] rsv;
    logic        rx_able;
    logic        mux_active;
    logic        ring_data;
    logic        ring_urc;
    logic        msg_notify;
    logic        carrier_line_follow;
    logic        ready_line_follow;
    logic [1:0]  power_saving_setting;
    logic        flow_control_select;
  } mcl_cfg_t;

  typedef struct packed {
    logic [25:0] rsv;
    logic        data_call;
    logic        input_prompt;
    logic        voice_call;
    logic        carrier;
    logic [1:0]  if_mode;
  } mcl_mode_t;

  typedef struct packed {
    logic [20:0] rsv;
    logic        ringing;
    logic        tx_pause;
    logic        idle_ok;
    logic        awake;
    logic        rx_en;
    logic        dtr_on;
    logic        rts_on;
    logic        ri_on;
    logic        dcd_on;
    logic        dsr_on;
    logic        cts_on;
  } mcl_status_t;

  localparam mcl_cfg_t CFG_RST = '{
    rsv: 22'h0, rx_able: 1'b1, mux_active: 1'b0, ring_data: 1'b0,
    ring_urc: 1'b0, msg_notify: 1'b0, carrier_line_follow: 1'b1,
    ready_line_follow: 1'b1, power_saving_setting: 2'h0,
    flow_control_select: 1'b1};
  localparam mcl_mode_t MODE_RST = '0;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } mcl_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } mcl_ahb_rsp_t;

endpackage

/* File: design/mcl_modem_lines.sv */
// Function
// - CTS ON (low) at initialization
// - CTS follows receiver enable, any flow setting
// - accept three characters after CTS OFF
// - mux flow by commands, CTS shows power
// - RTS defaults OFF, internal pull-up
// - RTS OFF pauses transmit when flow enabled
// - setting 2, no flow: RTS edge wakes receiver, 5 ms
// - setting 2, no flow: RTS ON keeps awake, OFF idles
// - DSR follow mode: ON only in data
// - DSR fixed mode: always ON
// - DTR defaults OFF, internal pull-up
// - setting 3 DTR edge wakes receiver, 5 ms
// - setting 3 DTR OFF disables receiver, idles
// - DCD follows carrier, voice call
// - dial sets DCD ON before connect
// - DCD ON during host input prompt
// - DCD held while any cause requests it
// - DCD fixed mode: always ON
// - call rings 1 s ON, 4 s OFF
// - message arrival gives 1 s ring pulse
// - events retrigger ring; answer ends early
// - selected extra events pulse ring 1 s
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module mcl_modem_lines #(
  parameter int unsigned TICK_CYCLES = mcl_pkg::TICK_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire mcl_pkg::mcl_ahb_req_t ahb_i,
  output mcl_pkg::mcl_ahb_rsp_t      ahb_o,
  input  wire logic                  rts_n_i,
  input  wire logic                  dtr_n_i,
  input  wire logic                  rx_char_i,
  output logic                       rx_accept_o,
  output logic                       cts_n_o,
  output logic                       dsr_n_o,
  output logic                       dcd_n_o,
  output logic                       ri_n_o,
  output logic                       rts_pullup_o,
  output logic                       dtr_pullup_o,
  output logic                       tx_pause_o,
  output logic                       mux_flow_on_o,
  output logic                       active_force_o,
  output logic                       idle_ok_o,
  output logic                       connect_o
);

  localparam int unsigned TW = 16;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [12:0] PER_LAST = 13'(mcl_pkg::RI_PERIOD_MS - 1);
  localparam logic [12:0] ON_MS    = 13'(mcl_pkg::RI_ON_MS);
  localparam logic [9:0]  HOLD_MS  = 10'(mcl_pkg::RI_ON_MS);
  localparam logic [2:0]  WAKE_T   = 3'(mcl_pkg::WAKE_MS);
  localparam logic [1:0]  GRACE    = 2'(mcl_pkg::RX_GRACE);

  // Only the low sixteen bytes are mapped; anything higher is a hole
  function automatic logic [3:0] reg_ofs(input logic [31:0] a);
    if (a[31:4] != 28'h0) begin
      reg_ofs = 4'h1;
    end else begin
      reg_ofs = a[3:0];
    end
  endfunction

  // Illegal mode code reads as command mode
  function automatic mcl_pkg::mcl_if_mode_t dec_mode(input logic [1:0] m);
    unique case (m)
      2'h1:    dec_mode = mcl_pkg::MCL_DATA;
      2'h2:    dec_mode = mcl_pkg::MCL_ONLINE;
      default: dec_mode = mcl_pkg::MCL_CMD;
    endcase
  endfunction

  // Declarations
  mcl_pkg::mcl_cfg_t    cfg_q, cfg_d;
  mcl_pkg::mcl_mode_t   mode_q, mode_d;
  mcl_pkg::mcl_ahb_rsp_t rsp_q, rsp_d;
  mcl_pkg::mcl_status_t stat;
  logic                 wr_pend_q, wr_pend_d;
  logic [3:0]           wr_ofs_q, wr_ofs_d;
  logic [mcl_pkg::EV_W-1:0] ev;
  logic [TW-1:0]        tick_cnt_q, tick_cnt_d;
  logic                 tick_q, tick_d;
  logic                 rts_on_q, rts_on_d, dtr_on_q, dtr_on_d;
  logic                 line_prev_q, line_prev_d;
  logic [2:0]           wake_cnt_q, wake_cnt_d;
  logic                 awake_q, awake_d;
  logic                 line_ctl, line_on, rx_en;
  logic                 ring_q, ring_d;
  logic [12:0]          phase_q, phase_d;
  logic [9:0]           hold_q, hold_d;
  logic                 ri_event;
  logic [1:0]           grace_q, grace_d;
  logic                 dial_q, dial_d;
  logic                 cts_n_d, dsr_n_d, dcd_n_d, ri_n_d;
  logic                 rx_accept_d, tx_pause_d, mux_flow_d;
  logic                 active_d, idle_d, connect_d;
  logic                 dcd_req;

  // Status word mirrors the pins as ON-true bits
  // Firmware reads these to tell power state from flow state
  always_comb begin
    stat          = '0;
    stat.cts_on   = ~cts_n_o;
    stat.dsr_on   = ~dsr_n_o;
    stat.dcd_on   = ~dcd_n_o;
    stat.ri_on    = ~ri_n_o;
    stat.rts_on   = rts_on_q;
    stat.dtr_on   = dtr_on_q;
    stat.rx_en    = rx_en;
    stat.awake    = awake_q;
    stat.idle_ok  = idle_ok_o;
    stat.tx_pause = tx_pause_o;
    stat.ringing  = ring_q;
  end

  // Bus slave: zero wait, read data prepared in the address phase
  always_comb begin
    logic take;
    take      = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
    wr_pend_d = take & ahb_i.hwrite;
    wr_ofs_d  = reg_ofs(ahb_i.haddr);
    rsp_d           = rsp_q;
    rsp_d.hreadyout = 1'b1;
    rsp_d.hresp     = 1'b0;
    if (take & ~ahb_i.hwrite) begin
      unique case (reg_ofs(ahb_i.haddr))
        mcl_pkg::OFS_CTRL: rsp_d.hrdata = cfg_q;
        mcl_pkg::OFS_MODE: rsp_d.hrdata = mode_q;
        mcl_pkg::OFS_STAT: rsp_d.hrdata = stat;
        default:           rsp_d.hrdata = 32'h0; // Events and holes read zero
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rsp_q     <= '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 4'h0;
    end else begin
      rsp_q     <= rsp_d;
      wr_pend_q <= wr_pend_d;
      wr_ofs_q  <= wr_ofs_d;
    end
  end

  // Response comes straight from its register
  assign ahb_o = rsp_q;

  // Register writes land in the data phase; unmapped writes drop
  always_comb begin
    cfg_d  = cfg_q;
    mode_d = mode_q;
    ev     = '0;
    if (wr_pend_q) begin
      unique case (wr_ofs_q)
        mcl_pkg::OFS_CTRL:  cfg_d  = ahb_i.hwdata;
        mcl_pkg::OFS_MODE:  mode_d = ahb_i.hwdata;
        mcl_pkg::OFS_EVENT: ev     = ahb_i.hwdata[mcl_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    cfg_d.rsv  = '0;
    mode_d.rsv = '0;
    // Dial request forces data mode so DCD rises first
    if (ev[mcl_pkg::EV_DIAL]) begin
      mode_d.if_mode = 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_q  <= mcl_pkg::CFG_RST;
      mode_q <= mcl_pkg::MODE_RST;
    end else begin
      cfg_q  <= cfg_d;
      mode_q <= mode_d;
    end
  end

  // Millisecond tick from the module clock
  // Ticks, not cycles, keep the ring counters narrow
  always_comb begin
    tick_d     = (tick_cnt_q == TICK_LAST);
    tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // Wake control by RTS (setting 2, no flow) or DTR (setting 3)
  // Receiver stays off until the count ends; early data would be garbled
  always_comb begin
    rts_on_d = ~rts_n_i;
    dtr_on_d = ~dtr_n_i;
    line_ctl = ((cfg_q.power_saving_setting == mcl_pkg::PSV_RTS)
                & ~cfg_q.flow_control_select)
               | (cfg_q.power_saving_setting == mcl_pkg::PSV_DTR);
    line_on  = (cfg_q.power_saving_setting == mcl_pkg::PSV_DTR)
               ? dtr_on_q : rts_on_q;
    line_prev_d = line_on;
    wake_cnt_d  = wake_cnt_q;
    awake_d     = awake_q;
    if (!line_ctl) begin
      wake_cnt_d = '0;
      awake_d    = 1'b1;
    end else if (!line_on) begin
      wake_cnt_d = '0;
      awake_d    = 1'b0;
    end else if (!line_prev_q) begin
      wake_cnt_d = '0;
      awake_d    = 1'b0;
    end else if (tick_q && !awake_q) begin
      // One tick extra so at least the full wake time passes
      wake_cnt_d = wake_cnt_q + 3'h1;
      awake_d    = (wake_cnt_q == WAKE_T);
    end
    rx_en = line_ctl ? (line_on & awake_q) : cfg_q.rx_able;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rts_on_q    <= 1'b0;
      dtr_on_q    <= 1'b0;
      line_prev_q <= 1'b0;
      wake_cnt_q  <= '0;
      awake_q     <= 1'b1;
    end else begin
      rts_on_q    <= rts_on_d;
      dtr_on_q    <= dtr_on_d;
      line_prev_q <= line_prev_d;
      wake_cnt_q  <= wake_cnt_d;
      awake_q     <= awake_d;
    end
  end

  // Ring indicator: call cadence plus retriggerable 1 s hold
  // Phase restarts on each new call so the first ON is a full second
  always_comb begin
    ri_event = (ev[mcl_pkg::EV_SMS] & cfg_q.msg_notify)
             | (ev[mcl_pkg::EV_URC] & cfg_q.ring_urc)
             | (ev[mcl_pkg::EV_DATA] & cfg_q.ring_data);
    // A new ring wins over an answer in the same cycle
    ring_d = ev[mcl_pkg::EV_RING]
           | (ring_q & ~ev[mcl_pkg::EV_ANSWER] & ~ev[mcl_pkg::EV_HANGUP]);
    if (!ring_d || !ring_q) begin
      phase_d = '0;
    end else if (tick_q) begin
      phase_d = (phase_q == PER_LAST) ? '0 : phase_q + 13'h1;
    end else begin
      phase_d = phase_q;
    end
    if (ri_event) begin
      hold_d = HOLD_MS;
    end else if (ev[mcl_pkg::EV_ANSWER]) begin
      hold_d = '0;
    end else if (tick_q && hold_q != '0) begin
      hold_d = hold_q - 10'h1;
    end else begin
      hold_d = hold_q;
    end
    ri_n_d = ~((ring_d & (phase_d < ON_MS)) | (hold_d != '0));
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ring_q  <= 1'b0;
      phase_q <= '0;
      hold_q  <= '0;
    end else begin
      ring_q  <= ring_d;
      phase_q <= phase_d;
      hold_q  <= hold_d;
    end
  end

  // Flow control, grace window and receive acceptance
  // Host may be mid-character when CTS drops, hence the grace count
  always_comb begin
    cts_n_d = ~rx_en;
    if (!cts_n_o) begin
      grace_d = '0;
    end else if (rx_char_i && grace_q < GRACE) begin
      grace_d = grace_q + 2'h1;
    end else begin
      grace_d = grace_q;
    end
    rx_accept_d = rx_char_i & (~cts_n_o | (grace_q < GRACE));
    // Under mux the flow rides on commands, not on the pins
    tx_pause_d  = cfg_q.flow_control_select & ~cfg_q.mux_active
                & ~rts_on_q;
    mux_flow_d  = cfg_q.flow_control_select & cfg_q.mux_active
                & rx_en;
    active_d    = line_ctl & line_on;
    if (cfg_q.power_saving_setting == mcl_pkg::PSV_OFF) begin
      idle_d = 1'b0;
    end else if (line_ctl) begin
      idle_d = ~line_on;
    end else begin
      idle_d = ~cfg_q.rx_able;
    end
  end

  // Mode lines: DSR and DCD
  // Fixed modes ignore the mode word entirely
  always_comb begin
    mcl_pkg::mcl_if_mode_t m;
    m = dec_mode(mode_q.if_mode);
    dsr_n_d = cfg_q.ready_line_follow
            ? (m != mcl_pkg::MCL_DATA)
            : 1'b0;
    // Any live cause keeps DCD ON until the last one drops
    dcd_req = mode_q.carrier | mode_q.voice_call
            | (m == mcl_pkg::MCL_DATA)
            | mode_q.input_prompt
            | ((m == mcl_pkg::MCL_ONLINE) & mode_q.data_call);
    dcd_n_d = cfg_q.carrier_line_follow ? ~dcd_req : 1'b0;
    // Connect only once DCD is already shown ON
    connect_d = dial_q & ~dcd_n_o;
    dial_d    = ev[mcl_pkg::EV_DIAL] | (dial_q & dcd_n_o);
  end

  // Pin and status flops; ON is the low level
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cts_n_o        <= 1'b0;
      dsr_n_o        <= 1'b1;
      dcd_n_o        <= 1'b1;
      ri_n_o         <= 1'b1;
      rts_pullup_o   <= 1'b1;
      dtr_pullup_o   <= 1'b1;
      rx_accept_o    <= 1'b0;
      tx_pause_o     <= 1'b1;
      mux_flow_on_o  <= 1'b0;
      active_force_o <= 1'b0;
      idle_ok_o      <= 1'b0;
      connect_o      <= 1'b0;
      grace_q        <= '0;
      dial_q         <= 1'b0;
    end else begin
      cts_n_o        <= cts_n_d;
      dsr_n_o        <= dsr_n_d;
      dcd_n_o        <= dcd_n_d;
      ri_n_o         <= ri_n_d;
      rts_pullup_o   <= 1'b1;
      dtr_pullup_o   <= 1'b1;
      rx_accept_o    <= rx_accept_d;
      tx_pause_o     <= tx_pause_d;
      mux_flow_on_o  <= mux_flow_d;
      active_force_o <= active_d;
      idle_ok_o      <= idle_d;
      connect_o      <= connect_d;
      grace_q        <= grace_d;
      dial_q         <= dial_d;
    end
  end

endmodule

`default_nettype wire

/* File: dv/mcl_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mcl_host_model (
  input  wire logic clk_i,
  input  wire logic rts_en_i,
  input  wire logic dtr_en_i,
  input  wire logic rts_pu_i,
  input  wire logic dtr_pu_i,
  output logic      rts_n_o,
  output logic      dtr_n_o
);
  // Host only pulls lines ON; a released line rests on the pull-up, else it wanders
  assign rts_n_o = rts_en_i ? 1'b0 : (rts_pu_i ? 1'b1 : clk_i);
  assign dtr_n_o = dtr_en_i ? 1'b0 : (dtr_pu_i ? 1'b1 : clk_i);
endmodule
`default_nettype wire

/* File: dv/mcl_modem_lines_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module mcl_modem_lines_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire mcl_pkg::mcl_ahb_rsp_t ahb_o,
  input wire logic                  rx_char_i,
  input wire logic                  rx_accept_o,
  input wire logic                  cts_n_o,
  input wire logic                  dsr_n_o,
  input wire logic                  dcd_n_o,
  input wire logic                  ri_n_o,
  input wire logic                  rts_pullup_o,
  input wire logic                  dtr_pullup_o,
  input wire logic                  active_force_o,
  input wire logic                  idle_ok_o,
  input wire logic                  connect_o
);
  logic [2:0] off_q;
  logic [2:0] off_d;

  // Characters seen since clear-to-send went OFF, saturating
  always_comb begin
    off_d = off_q;
    if (!cts_n_o) off_d = 3'h0;
    else if (rx_char_i && off_q != 3'h7) off_d = off_q + 3'h1;
  end

  // Saturation keeps a long OFF spell from wrapping back into the grace window
  always_ff @(posedge clk_i) begin
    off_q <= sys_rst_i ? 3'h0 : off_d;
  end

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_char_on;
    rx_char_i && !cts_n_o;
  endsequence
  sequence s_char_late;
    rx_char_i && cts_n_o && off_q >= 3'h3;
  endsequence

  property p_pullups;
    rts_pullup_o && dtr_pullup_o;
  endproperty
  a_pullups: assert property (p_pullups)
    else $error("pull-up enable dropped");
  property p_init;
    $past(sys_rst_i) |-> !cts_n_o && dsr_n_o && dcd_n_o && ri_n_o;
  endproperty
  a_init: assert property (p_init)
    else $error("line levels wrong after reset");
  property p_acc_on;
    s_char_on |=> rx_accept_o;
  endproperty
  a_acc_on: assert property (p_acc_on)
    else $error("character lost while clear-to-send ON");
  property p_acc_late;
    s_char_late |=> !rx_accept_o;
  endproperty
  a_acc_late: assert property (p_acc_late)
    else $error("character taken beyond grace count");
  property p_acc_cause;
    rx_accept_o |-> $past(rx_char_i);
  endproperty
  a_acc_cause: assert property (p_acc_cause)
    else $error("accept without a character");
  property p_connect;
    connect_o |-> !dcd_n_o && $past(dcd_n_o) == 1'b0;
  endproperty
  a_connect: assert property (p_connect)
    else $error("connect before carrier-detect ON");
  property p_connect_pulse;
    connect_o |=> !connect_o;
  endproperty
  a_connect_pulse: assert property (p_connect_pulse)
    else $error("connect longer than one cycle");
  property p_idle;
    active_force_o |-> !idle_ok_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle allowed while forced active");
  property p_wake;
    $rose(active_force_o) |-> cts_n_o [*8];
  endproperty
  a_wake: assert property (p_wake)
    else $error("clear-to-send ON before wake delay");
  property p_okay;
    ahb_o.hreadyout && !ahb_o.hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus response not ready and OKAY");
endmodule

bind mcl_modem_lines mcl_modem_lines_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_i          (clk_i),
  .sys_rst_i      (sys_rst_i),
  .ahb_o          (ahb_o),
  .rx_char_i      (rx_char_i),
  .rx_accept_o    (rx_accept_o),
  .cts_n_o        (cts_n_o),
  .dsr_n_o        (dsr_n_o),
  .dcd_n_o        (dcd_n_o),
  .ri_n_o         (ri_n_o),
  .rts_pullup_o   (rts_pullup_o),
  .dtr_pullup_o   (dtr_pullup_o),
  .active_force_o (active_force_o),
  .idle_ok_o      (idle_ok_o),
  .connect_o      (connect_o)
);
`default_nettype wire

/* File: dv/mcl_modem_lines_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module mcl_modem_lines_tb_top;
  localparam int TK = 4;
  localparam logic [31:0] A_C = 32'h0;
  localparam logic [31:0] A_M = 32'h4;
  localparam logic [31:0] A_E = 32'h8;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] mode;
    logic [1:0]  dsr_dcd_n;
  } mcl_row_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic rx_char_i = 1'b0;
  logic rts_en = 1'b0;
  logic dtr_en = 1'b0;
  mcl_pkg::mcl_ahb_req_t req = '0;
  mcl_pkg::mcl_ahb_rsp_t ahb_o;
  logic rts_n, dtr_n, rts_pu, dtr_pu, rx_accept_o, cts_n_o, dsr_n_o, dcd_n_o, ri_n_o;
  logic tx_pause_o, mux_flow_on_o, active_force_o, idle_ok_o, connect_o;
  logic [3:0] mon;
  logic [31:0] rd;
  int errors = 0;
  int check_count = 0;
  int n;
  // Follow, fixed and mode combinations with expected DSR, DCD pins
  mcl_row_t rows [8] = '{'{32'h219, 32'h00, 2'b11}, '{32'h219, 32'h05, 2'b00},
    '{32'h219, 32'h22, 2'b10}, '{32'h219, 32'h10, 2'b10}, '{32'h219, 32'h08, 2'b10},
    '{32'h219, 32'h04, 2'b10}, '{32'h211, 32'h00, 2'b01}, '{32'h209, 32'h00, 2'b10}};
  logic [31:0] evs [3] = '{32'h04, 32'h08, 32'h10};

  always #50 clk_i = ~clk_i;
  assign mon = {connect_o, active_force_o, cts_n_o, ri_n_o};

  mcl_modem_lines #(.TICK_CYCLES(TK)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ahb_i({req[$bits(req)-1:1], ahb_o.hreadyout}), .ahb_o(ahb_o), .rts_n_i(rts_n),
    .dtr_n_i(dtr_n), .rx_char_i(rx_char_i), .rx_accept_o(rx_accept_o), .cts_n_o(cts_n_o),
    .dsr_n_o(dsr_n_o), .dcd_n_o(dcd_n_o), .ri_n_o(ri_n_o), .rts_pullup_o(rts_pu),
    .dtr_pullup_o(dtr_pu), .tx_pause_o(tx_pause_o), .mux_flow_on_o(mux_flow_on_o),
    .active_force_o(active_force_o), .idle_ok_o(idle_ok_o), .connect_o(connect_o));
  mcl_host_model host (.clk_i(clk_i), .rts_en_i(rts_en), .dtr_en_i(dtr_en),
    .rts_pu_i(rts_pu), .dtr_pu_i(dtr_pu), .rts_n_o(rts_n), .dtr_n_o(dtr_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait on a monitored line; slip of the bound ends the run
  task automatic wait_for(input int k, input logic v, output int cnt);
    cnt = 0;
    while (mon[k] !== v && cnt < 30000) begin
      @(posedge clk_i);
      cnt++;
    end
    if (cnt >= 30000) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // Single AHB word transfer; read data lands in rd
  task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd);
    int w;
    w = 0;
    req <= '{hsel: 1'b1, haddr: a, htrans: 2'h2, hwrite: wr, hsize: 3'h2,
             hwdata: req.hwdata, hready: 1'b0};
    // Each phase stands until hready is seen high at an edge
    do begin
      @(posedge clk_i);
      w++;
    end while (ahb_o.hreadyout !== 1'b1 && w < 50);
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    do begin
      @(posedge clk_i);
      w++;
    end while (ahb_o.hreadyout !== 1'b1 && w < 50);
    rd = ahb_o.hrdata;
    if (w >= 50) begin
      errors++;
      print_verdict();
    end
  endtask

  function automatic logic near(input int cnt, input int ms);
    return cnt >= ms * TK - 16 && cnt <= ms * TK + 16;
  endfunction

  // Drive k characters in a row and count accept pulses
  task automatic chars(input int k, input int exp);
    int acc;
    acc = 0;
    for (int i = 0; i < 8; i++) begin
      rx_char_i <= (i < k);
      @(posedge clk_i);
      acc += rx_accept_o;
    end
    chk(acc, exp);
  endtask

  task automatic wake(input logic dtr);
    int t;
    bus(A_C, 1'b1, dtr ? 32'h21e : 32'h21c);
    cyc(4);
    chk(cts_n_o, 1'b1);
    if (dtr) dtr_en <= 1'b1;
    else rts_en <= 1'b1;
    wait_for(2, 1'b1, t);
    wait_for(1, 1'b0, t);
    chk(t >= mcl_pkg::WAKE_MS * TK - 2, 1'b1);
    chk({active_force_o, idle_ok_o}, 2'b10);
    chars(2, 2);
    dtr_en <= 1'b0;
    rts_en <= 1'b0;
    wait_for(1, 1'b1, t);
    chk(idle_ok_o, 1'b1);
    chars(5, 3);
  endtask

  initial begin
    cyc(20);
    sys_rst_i <= 1'b0;
    cyc(2);
    chk({cts_n_o, dsr_n_o, dcd_n_o, ri_n_o}, 4'h7);
    chk({rts_pu, dtr_pu, rts_n, dtr_n}, 4'hf);
    bus(A_C, 1'b0, 32'h0);
    chk(rd, 32'h219);
    bus(32'hc, 1'b0, 32'h0);
    chk(rd & 32'h7f, 32'h41);
    bus(32'h10, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(A_E, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(A_C, 1'b1, rows[i].ctrl);
      bus(A_M, 1'b1, rows[i].mode);
      cyc(3);
      chk({dsr_n_o, dcd_n_o}, rows[i].dsr_dcd_n);
    end
    bus(A_M, 1'b1, 32'h0);
    $display("test line table done");
    chk(tx_pause_o, 1'b1);
    rts_en <= 1'b1;
    cyc(4);
    chk(tx_pause_o, 1'b0);
    bus(A_C, 1'b1, 32'h319);
    rts_en <= 1'b0;
    cyc(4);
    chk({tx_pause_o, cts_n_o, mux_flow_on_o}, 3'b001);
    $display("test flow done");
    wake(1'b0);
    wake(1'b1);
    bus(A_C, 1'b1, 32'h219);
    $display("test wake done");
    bus(A_E, 1'b1, 32'h01);
    wait_for(0, 1'b0, n);
    wait_for(0, 1'b1, n);
    chk(near(n, mcl_pkg::RI_ON_MS), 1'b1);
    wait_for(0, 1'b0, n);
    chk(near(n, mcl_pkg::RI_PERIOD_MS - mcl_pkg::RI_ON_MS), 1'b1);
    cyc(100);
    bus(A_E, 1'b1, 32'h02);
    wait_for(0, 1'b1, n);
    chk(n < 8, 1'b1);
    cyc(20500);
    chk(ri_n_o, 1'b1);
    bus(A_E, 1'b1, 32'h01);
    wait_for(0, 1'b0, n);
    bus(A_E, 1'b1, 32'h40);
    wait_for(0, 1'b1, n);
    chk(n < 8, 1'b1);
    $display("test call ring done");
    bus(A_E, 1'b1, 32'h04);
    cyc(50);
    chk(ri_n_o, 1'b1);
    bus(A_C, 1'b1, 32'h2f9);
    foreach (evs[i]) begin
      bus(A_E, 1'b1, evs[i]);
      wait_for(0, 1'b0, n);
      wait_for(0, 1'b1, n);
      chk(near(n, mcl_pkg::RI_ON_MS), 1'b1);
    end
    bus(A_E, 1'b1, 32'h04);
    cyc(2000);
    chk(ri_n_o, 1'b0);
    bus(A_E, 1'b1, 32'h08);
    wait_for(0, 1'b1, n);
    chk(near(n, mcl_pkg::RI_ON_MS), 1'b1);
    $display("test events done");
    bus(A_E, 1'b1, 32'h20);
    wait_for(3, 1'b1, n);
    chk(n < 8, 1'b1);
    chk({dcd_n_o, dsr_n_o}, 2'b00);
    bus(A_E, 1'b1, 32'h40);
    $display("test dial done");
    sys_rst_i <= 1'b1;
    cyc(2);
    sys_rst_i <= 1'b0;
    cyc(2);
    chk({cts_n_o, dsr_n_o, dcd_n_o, ri_n_o, tx_pause_o}, 5'h0f);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
